// File: hw/ncs_pkg.sv
// package of constants, types and register map for the node config and indicator block
//
// Overview of operation
// - node id from tens and units switches
// - bit-rate switch maps to eight kbit rates
// - run indicator follows operating state
// - error indicator follows error state
// - termination indicator follows termination switch
// - per-input isolated or ttl path, isolated default
// - counting logic sees falling edges, active low
// - isolated path inverted, invert off passes it
// - ttl path follows pin, invert on flips it
package ncs_pkg;
  // ===========================================================
  // timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_OFF_MS = 1000;
  localparam int unsigned BLINK_HALF_MS = 200;
  localparam int unsigned FLASH_ON_CYC = (CLK_HZ / 1000) * FLASH_ON_MS;
  localparam int unsigned FLASH_OFF_CYC = (CLK_HZ / 1000) * FLASH_OFF_MS;
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int unsigned NUM_IN = 8;
  // ===========================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IN_SEL = 8'h04;
  localparam logic [7:0] ADDR_IN_INV = 8'h08;
  localparam logic [7:0] ADDR_SWITCH = 8'h0c;
  localparam logic [7:0] ADDR_IN_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
  // reset values: isolated path (0) with invert off on every input
  localparam logic [7:0] IN_SEL_RST = 8'h00;
  localparam logic [7:0] IN_INV_RST = 8'h00;
  // control field positions
  localparam int unsigned CTRL_RUN_LSB = 0;
  localparam int unsigned CTRL_ERR_LSB = 4;
  // switch register field positions
  localparam int unsigned SW_ID_LSB = 0;
  localparam int unsigned SW_RATE_LSB = 8;
  localparam int unsigned SW_KBPS_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ===========================================================
  // types
  typedef enum logic [1:0] {
    RUN_OFF = 2'h0,
    RUN_STOPPED = 2'h1,
    RUN_PREOP = 2'h2,
    RUN_OPER = 2'h3
  } ncs_run_t;
  typedef enum logic [1:0] {
    ERR_NONE = 2'h0,
    ERR_WARN = 2'h1,
    ERR_GUARD = 2'h2,
    ERR_BUSOFF = 2'h3
  } ncs_err_t;
  typedef struct packed {
    logic run;
    logic err;
    logic term;
  } ncs_led_t;
  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] units;
    logic [2:0] rate;
  } ncs_sw_t;
  // bit rate in kbit/s for the rate switch value
  function automatic logic [10:0] rate_kbps(input logic [2:0] sel);
    logic [10:0] r;
    unique case (sel)
      3'h0: r = 11'd10;
      3'h1: r = 11'd20;
      3'h2: r = 11'd50;
      3'h3: r = 11'd125;
      3'h4: r = 11'd250;
      3'h5: r = 11'd500;
      3'h6: r = 11'd800;
      default: r = 11'd1000;
    endcase
    return r;
  endfunction : rate_kbps
endpackage : ncs_pkg

// File: hw/ncs_ind_gen.sv
// indicator pattern generator: free-running flash and blink phases
`timescale 1ns/1ps
`default_nettype none
module ncs_ind_gen #(
  parameter int unsigned FLASH_ON = ncs_pkg::FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF = ncs_pkg::FLASH_OFF_CYC,
  parameter int unsigned BLINK_HALF = ncs_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // pattern phases
  output logic flash,
  output logic blink
);
  logic [25:0] fcnt_reg;
  logic [25:0] bcnt_reg;
  logic flash_reg;
  logic blink_reg;
  logic [25:0] f_lim;
  // each phase reloads from its own length; a shared base would lock blink to flash
  assign f_lim = flash_reg ? 26'(FLASH_ON - 1) : 26'(FLASH_OFF - 1);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fcnt_reg <= 26'h0;
      bcnt_reg <= 26'h0;
      flash_reg <= 1'b0;
      blink_reg <= 1'b0;
    end else begin
      fcnt_reg <= (fcnt_reg >= f_lim) ? 26'h0 : fcnt_reg + 26'h1;
      if (fcnt_reg >= f_lim) flash_reg <= ~flash_reg;
      bcnt_reg <= (bcnt_reg >= 26'(BLINK_HALF - 1)) ? 26'h0 : bcnt_reg + 26'h1;
      if (bcnt_reg >= 26'(BLINK_HALF - 1)) blink_reg <= ~blink_reg;
    end
  end
  assign flash = flash_reg;
  assign blink = blink_reg;
endmodule : ncs_ind_gen
`default_nettype wire

// File: hw/ncs_top.sv
// node config, status indicators and input conditioning with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module ncs_top #(
  parameter int unsigned FLASH_ON = ncs_pkg::FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF = ncs_pkg::FLASH_OFF_CYC,
  parameter int unsigned BLINK_HALF = ncs_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // switch pins
  input wire logic [3:0] sw_id_tens,
  input wire logic [3:0] sw_id_units,
  input wire logic [2:0] sw_rate,
  input wire logic sw_term,
  // counter input pins
  input wire logic [7:0] cnt_pin,
  // configuration outputs
  output logic [6:0] node_id,
  output logic [2:0] rate_sel,
  output logic [10:0] rate_kbps,
  // conditioned inputs to counting logic, active low, and their active-high falling-edge pulses
  output logic [7:0] cnt_in_n,
  output logic [7:0] cnt_fall,
  // indicators
  output ncs_pkg::ncs_led_t led,
  // interrupt
  output logic irq
);
  // ===========================================================
  // pin synchronisers
  ncs_pkg::ncs_sw_t sw_s1_reg;
  ncs_pkg::ncs_sw_t sw_s2_reg;
  logic term_s1_reg;
  logic term_s2_reg;
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  // two stages on every pin; switches may be turned while powered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sw_s1_reg <= '0;
      sw_s2_reg <= '0;
      term_s1_reg <= 1'b0;
      term_s2_reg <= 1'b0;
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      sw_s1_reg <= '{tens: sw_id_tens, units: sw_id_units, rate: sw_rate};
      sw_s2_reg <= sw_s1_reg;
      term_s1_reg <= sw_term;
      term_s2_reg <= term_s1_reg;
      pin_s1_reg <= cnt_pin;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ===========================================================
  // configuration decode
  logic [6:0] id_next;
  logic [10:0] kbps_next;
  // tens digit times ten plus units digit
  assign id_next = 7'({sw_s2_reg.tens, 3'h0}) + 7'({sw_s2_reg.tens, 1'h0})
                   + 7'(sw_s2_reg.units);
  assign kbps_next = ncs_pkg::rate_kbps(sw_s2_reg.rate);
  logic [6:0] node_id_reg;
  logic [2:0] rate_sel_reg;
  logic [10:0] kbps_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      node_id_reg <= 7'h00;
      rate_sel_reg <= 3'h0;
      kbps_reg <= 11'h000;
    end else begin
      node_id_reg <= id_next;
      rate_sel_reg <= sw_s2_reg.rate;
      kbps_reg <= kbps_next;
    end
  end
  assign node_id = node_id_reg;
  assign rate_sel = rate_sel_reg;
  assign rate_kbps = kbps_reg;

  // ===========================================================
  // input conditioning
  logic [7:0] in_sel_reg;
  logic [7:0] in_inv_reg;
  logic [7:0] internal_sig;
  logic [7:0] cond_next;
  logic [7:0] cond_reg;
  // isolated path (sel 0) inverts the pin, ttl path (sel 1) follows it
  assign internal_sig = (~pin_s2_reg & ~in_sel_reg) | (pin_s2_reg & in_sel_reg);
  // invert selection xors the internal signal toward active low
  assign cond_next = internal_sig ^ in_inv_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cond_reg <= 8'hff; // idle high so no false edge at release
    end else begin
      cond_reg <= cond_next;
    end
  end
  assign cnt_in_n = cond_reg;
  // falling edge of the active-low signal is the count event
  logic [7:0] fall_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fall_reg <= 8'h00;
    end else begin
      fall_reg <= cond_reg & ~cond_next;
    end
  end
  assign cnt_fall = fall_reg;

  // ===========================================================
  // indicators
  logic flash;
  logic blink;
  ncs_ind_gen #(
    .FLASH_ON(FLASH_ON),
    .FLASH_OFF(FLASH_OFF),
    .BLINK_HALF(BLINK_HALF)
  ) u_gen (
    .clock(clock),
    .nrst(nrst),
    .flash(flash),
    .blink(blink)
  );
  ncs_pkg::ncs_run_t run_state_reg;
  ncs_pkg::ncs_err_t err_state_reg;
  logic run_led;
  logic err_led;
  // run indicator per operating state
  always_comb begin
    unique case (run_state_reg)
      ncs_pkg::RUN_OFF: run_led = 1'b0;
      ncs_pkg::RUN_STOPPED: run_led = flash;
      ncs_pkg::RUN_PREOP: run_led = blink;
      ncs_pkg::RUN_OPER: run_led = 1'b1;
    endcase
  end
  // error indicator per error state
  always_comb begin
    unique case (err_state_reg)
      ncs_pkg::ERR_NONE: err_led = 1'b0;
      ncs_pkg::ERR_WARN: err_led = flash;
      ncs_pkg::ERR_GUARD: err_led = blink;
      ncs_pkg::ERR_BUSOFF: err_led = 1'b1;
    endcase
  end
  // one register ahead of the indicator pins keeps them free of decode glitches
  ncs_pkg::ncs_led_t led_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      led_reg <= '0;
    end else begin
      led_reg <= '{run: run_led, err: err_led, term: term_s2_reg};
    end
  end
  assign led = led_reg;

  // ===========================================================
  // interrupt events: any count edge, id change, rate change, term change
  logic [10:0] ev_next;
  logic [10:0] irq_stat_reg;
  logic [10:0] irq_en_reg;
  logic [10:0] irq_clr;
  logic ev_id;
  logic ev_rate;
  logic ev_term;
  // a change shows for one cycle, while the registered copy still holds the old value
  assign ev_id = node_id_reg != id_next;
  assign ev_rate = rate_sel_reg != sw_s2_reg.rate;
  assign ev_term = term_s2_reg != led_reg.term;
  // status order: termination, rate, id, then one bit per counter input
  assign ev_next = {ev_term, ev_rate, ev_id, fall_reg};

  // ===========================================================
  // axi4-lite slave
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_go;
  logic rd_go;
  logic wr_map;
  logic rd_map;
  logic [31:0] rd_mux;
  logic wr_ctrl;
  logic wr_in_sel;
  logic wr_in_inv;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic [31:0] ctrl_rd;
  // accept each channel once, one write outstanding until bready
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_map = (aw_addr_reg == ncs_pkg::ADDR_CTRL) || (aw_addr_reg == ncs_pkg::ADDR_IN_SEL)
                  || (aw_addr_reg == ncs_pkg::ADDR_IN_INV) || (aw_addr_reg == ncs_pkg::ADDR_IRQ_CLR)
                  || (aw_addr_reg == ncs_pkg::ADDR_IRQ_EN);
  // field writes need the low byte lane; without it the write answers but changes nothing
  assign wr_ctrl = wr_go && w_strb_reg[0] && (aw_addr_reg == ncs_pkg::ADDR_CTRL);
  assign wr_in_sel = wr_go && w_strb_reg[0] && (aw_addr_reg == ncs_pkg::ADDR_IN_SEL);
  assign wr_in_inv = wr_go && w_strb_reg[0] && (aw_addr_reg == ncs_pkg::ADDR_IN_INV);
  assign wr_irq_en = wr_go && w_strb_reg[0] && (aw_addr_reg == ncs_pkg::ADDR_IRQ_EN);
  assign wr_irq_clr = wr_go && w_strb_reg[0] && (aw_addr_reg == ncs_pkg::ADDR_IRQ_CLR);
  // the upper status bits of a clear ride on the second byte lane
  assign irq_clr = wr_irq_clr
                   ? {w_strb_reg[1] ? w_data_reg[10:8] : 3'h0, w_data_reg[7:0]} : 11'h000;
  // control readback places each state at its own field position
  assign ctrl_rd = (32'(run_state_reg) << ncs_pkg::CTRL_RUN_LSB)
                   | (32'(err_state_reg) << ncs_pkg::CTRL_ERR_LSB);
  // read data selection; the map ends at the enable register
  assign rd_map = (s_axi_araddr <= ncs_pkg::ADDR_IRQ_EN) && (s_axi_araddr[1:0] == 2'h0);
  assign rd_mux =
    (s_axi_araddr == ncs_pkg::ADDR_CTRL) ? ctrl_rd :
    (s_axi_araddr == ncs_pkg::ADDR_IN_SEL) ? {24'h0, in_sel_reg} :
    (s_axi_araddr == ncs_pkg::ADDR_IN_INV) ? {24'h0, in_inv_reg} :
    (s_axi_araddr == ncs_pkg::ADDR_SWITCH) ?
      ((32'(node_id_reg) << ncs_pkg::SW_ID_LSB) | (32'(rate_sel_reg) << ncs_pkg::SW_RATE_LSB)
       | (32'(kbps_reg) << ncs_pkg::SW_KBPS_LSB)) :
    (s_axi_araddr == ncs_pkg::ADDR_IN_LEVEL) ? {24'h0, cond_reg} :
    (s_axi_araddr == ncs_pkg::ADDR_IRQ_STAT) ? {21'h0, irq_stat_reg} :
    (s_axi_araddr == ncs_pkg::ADDR_IRQ_EN) ? {21'h0, irq_en_reg} : 32'h0;
  // capture address and data in either order
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_reg <= 1'b0;
      end
    end
  end
  // write response
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= ncs_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? ncs_pkg::RESP_OKAY : ncs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  // writable registers, low byte lane carries fields, second lane the upper enable bits
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_state_reg <= ncs_pkg::RUN_OFF;
      err_state_reg <= ncs_pkg::ERR_NONE;
      in_sel_reg <= ncs_pkg::IN_SEL_RST;
      in_inv_reg <= ncs_pkg::IN_INV_RST;
      irq_en_reg <= 11'h000;
    end else begin
      if (wr_ctrl) begin
        run_state_reg <= ncs_pkg::ncs_run_t'(w_data_reg[ncs_pkg::CTRL_RUN_LSB +: 2]);
        err_state_reg <= ncs_pkg::ncs_err_t'(w_data_reg[ncs_pkg::CTRL_ERR_LSB +: 2]);
      end
      if (wr_in_sel) in_sel_reg <= w_data_reg[7:0];
      if (wr_in_inv) in_inv_reg <= w_data_reg[7:0];
      if (wr_irq_en) begin
        irq_en_reg <= {w_strb_reg[1] ? w_data_reg[10:8] : irq_en_reg[10:8], w_data_reg[7:0]};
      end
    end
  end
  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_stat_reg <= 11'h000;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | ev_next;
    end
  end
  // read channel
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= ncs_pkg::RESP_OKAY;
    end else begin
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_map ? ncs_pkg::RESP_OKAY : ncs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  // answer channels leave straight from flops
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // level interrupt, high while an enabled status bit is set
  assign irq = |(irq_stat_reg & irq_en_reg);
endmodule : ncs_top
`default_nettype wire

// File: bench/ncs_top_sva.sv
// checker of bus answers, switch decoding, termination indicator and input edges
`timescale 1ns/1ps
`default_nettype none
module ncs_top_sva (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // pins and outputs
  input wire logic [3:0] sw_id_tens,
  input wire logic [3:0] sw_id_units,
  input wire logic [2:0] sw_rate,
  input wire logic sw_term,
  input wire logic [6:0] node_id,
  input wire logic [2:0] rate_sel,
  input wire logic [10:0] rate_kbps,
  input wire logic [7:0] cnt_in_n,
  input wire logic [7:0] cnt_fall,
  input wire ncs_pkg::ncs_led_t led
);
  // ==========================================
  // helpers
  localparam logic [10:0] KB [8] = '{11'd10, 11'd20, 11'd50, 11'd125,
    11'd250, 11'd500, 11'd800, 11'd1000};
  logic [2:0] up_reg;
  wire logic full;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // edges since reset; the pin pipelines hold stale reset values before three
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) up_reg <= 3'h0;
    else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
  end
  assign full = (up_reg == 3'h4);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================
  // assertions
  a_node_id_sum: assert property (full |-> node_id ==
    {3'h0, $past(sw_id_tens, 3)} * 7'd10 + {3'h0, $past(sw_id_units, 3)})
    else $error("node id not tens times ten plus units");
  a_rate_follow: assert property (full |-> rate_sel == $past(sw_rate, 3))
    else $error("rate select does not follow switch");
  a_rate_table: assert property (full |-> rate_kbps == KB[rate_sel])
    else $error("bit rate does not match select");
  a_term_follow: assert property (full |-> led.term == $past(sw_term, 3))
    else $error("termination indicator does not follow switch");
  a_fall_pulse: assert property (full |->
    cnt_fall == ($past(cnt_in_n) & ~cnt_in_n))
    else $error("falling edge pulse wrong");
  a_idle_high: assert property ($rose(nrst) |-> cnt_in_n == 8'hff)
    else $error("count inputs not idle high after reset");
  a_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data missing");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule : ncs_top_sva
bind ncs_top ncs_top_sva u_sva (.clock, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .sw_id_tens, .sw_id_units, .sw_rate, .sw_term, .node_id,
  .rate_sel, .rate_kbps, .cnt_in_n, .cnt_fall, .led);
`default_nettype wire

// File: bench/ncs_pin_model.sv
// model of the field side: rotary switches, termination switch, counter pins
`timescale 1ns/1ps
`default_nettype none
module ncs_pin_model (
  // clock
  input wire logic clock,
  // field pins
  output logic [3:0] sw_id_tens,
  output logic [3:0] sw_id_units,
  output logic [2:0] sw_rate,
  output logic sw_term,
  output logic [7:0] cnt_pin
);
  // ==========================================
  // pin drive; levels move only right after a rising edge
  initial begin
    sw_id_tens = 4'h0;
    sw_id_units = 4'h0;
    sw_rate = 3'h0;
    sw_term = 1'b0;
    cnt_pin = 8'h00;
  end
  task automatic set_sw(input logic [3:0] t, u, input logic [2:0] r, input logic tm);
    @(posedge clock);
    sw_id_tens <= t;
    sw_id_units <= u;
    sw_rate <= r;
    sw_term <= tm;
  endtask : set_sw
  task automatic set_pins(input logic [7:0] p);
    @(posedge clock);
    cnt_pin <= p;
  endtask : set_pins
endmodule : ncs_pin_model
`default_nettype wire

// File: bench/ncs_top_tb_top.sv
// self-checking bench of the node config and indicator block
`timescale 1ns/1ps
`default_nettype none
module ncs_top_tb_top;
  // ==========================================
  // signals
  logic clock, nrst, sw_term, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cnt_pin, cnt_in_n, cnt_fall, pv, sv, iv;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, sw_id_tens, sw_id_units;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] sw_rate, rate_sel;
  logic [6:0] node_id;
  logic [10:0] rate_kbps;
  ncs_pkg::ncs_led_t led;
  int n_errors = 0, n_compared = 0, cyc = 0, nr, ne;
  int kb [8] = '{10, 20, 50, 125, 250, 500, 800, 1000};
  // short pattern counts keep the run brief; lit counts are over one flash period
  localparam int FON = 4, FOFF = 20, BH = 4;
  int lit [4] = '{0, FON, (FON + FOFF) / 2, FON + FOFF};
  logic [7:0] sel_t [4] = '{8'h00, 8'hff, 8'h0f, 8'hcc};
  logic [7:0] inv_t [4] = '{8'h00, 8'hff, 8'h55, 8'h0f};
  // ==========================================
  // design and field model
  ncs_top #(.FLASH_ON(FON), .FLASH_OFF(FOFF), .BLINK_HALF(BH)) dut (.clock, .nrst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sw_id_tens, .sw_id_units, .sw_rate, .sw_term,
    .cnt_pin, .node_id, .rate_sel, .rate_kbps, .cnt_in_n, .cnt_fall, .led, .irq);
  ncs_pin_model pm (.clock, .sw_id_tens, .sw_id_units, .sw_rate, .sw_term, .cnt_pin);
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test;
    end
  end
  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // bus master: hold each channel until taken, bready until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'b00);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask : rd
  task automatic ci(input logic e);
    // pin to status takes two sync stages, the level register, the edge and the sticky bit
    repeat (6) @(posedge clock);
    chk("irq", e, irq);
  endtask : ci
  task end_of_test;
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // ==========================================
  // main sequence
  initial begin
    {nrst, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd(ncs_pkg::ADDR_IN_SEL, 32'h0);
    rd(ncs_pkg::ADDR_IN_INV, 32'h0);
    rd(ncs_pkg::ADDR_IN_LEVEL, 32'hff);
    wr(8'h20, 32'h1, ncs_pkg::RESP_SLVERR);
    wr(ncs_pkg::ADDR_SWITCH, 32'h1, ncs_pkg::RESP_SLVERR);
    rd(8'h24, 32'h0, ncs_pkg::RESP_SLVERR);
    // every rate code, with the termination switch toggling alongside
    for (int r = 0; r < 8; r++) begin
      pm.set_sw(4'(r + 2), 4'(r), 3'(r), r[0]);
      repeat (6) @(posedge clock);
      rd(ncs_pkg::ADDR_SWITCH, (kb[r] << 16) | (r << 8) | ((r + 2) * 10 + r));
      chk("term led", r[0], led.term);
    end
    // id, rate and termination changes all left their sticky bits, no input edge did
    rd(ncs_pkg::ADDR_IRQ_STAT, 32'h700);
    // path and invert mixes, bit by bit
    for (int k = 0; k < 4; k++) begin
      sv = sel_t[k];
      iv = inv_t[k];
      pv = 8'ha5 ^ 8'(k);
      wr(ncs_pkg::ADDR_IN_SEL, {24'h0, sv});
      wr(ncs_pkg::ADDR_IN_INV, {24'h0, iv});
      pm.set_pins(pv);
      repeat (5) @(posedge clock);
      rd(ncs_pkg::ADDR_IN_LEVEL, {24'h0, ((sv & pv) | (~sv & ~pv)) ^ iv});
    end
    // falling edge raises a sticky, maskable, clearable event
    wr(ncs_pkg::ADDR_IN_SEL, 32'h0);
    wr(ncs_pkg::ADDR_IN_INV, 32'h0);
    pm.set_pins(8'h00);
    repeat (5) @(posedge clock);
    wr(ncs_pkg::ADDR_IRQ_CLR, 32'h7ff);
    wr(ncs_pkg::ADDR_IRQ_EN, 32'h1);
    ci(1'b0);
    pm.set_pins(8'h01);
    ci(1'b1);
    rd(ncs_pkg::ADDR_IRQ_STAT, 32'h1);
    wr(ncs_pkg::ADDR_IRQ_EN, 32'h0);
    ci(1'b0);
    wr(ncs_pkg::ADDR_IRQ_EN, 32'h1);
    ci(1'b1);
    wr(ncs_pkg::ADDR_IRQ_CLR, 32'h1);
    ci(1'b0);
    // each run and error state: lit cycles over one flash period
    for (int s = 0; s < 4; s++) begin
      wr(ncs_pkg::ADDR_CTRL, 32'(s | (s << 4)));
      repeat (2) @(posedge clock);
      nr = 0;
      ne = 0;
      repeat (FON + FOFF) begin
        @(posedge clock);
        nr += led.run;
        ne += led.err;
      end
      chk("run lit cycles", lit[s], nr);
      chk("err lit cycles", lit[s], ne);
    end
    end_of_test;
  end
endmodule : ncs_top_tb_top
`default_nettype wire
